// ==== src/ipst_status_timing.sv ====
// Protocol status, address-match status and SDA hold/setup timing
// for a controller in two-wire bus mode.
// Assumes a protocol engine on clk for event pulses and open-drain pads
// outside; SCL and SDA arrive asynchronously.
//
// Summary of operation
// R01: Wake frame direction bit stored in bit 17
// R02: Wake ack done sticks while wake flag set
// R03: Slave read request status follows hardware
// R04: Slave selected status follows hardware
// R05: Master ack received sets flag bit 13
// R06: Misplaced START or STOP sets bus error
// R07: Software uses stop control after slave error
// R08: Lost arbitration sets flag bit 11
// R09: Master nack received sets flag bit 10
// R10: Detected STOP sets flag bit 9
// R11: START sets flag; slave only repeated START
// R12: Bus busy between START and STOP
// R13: Time-out event sets flag bit 5
// R14: Flags clear only by writing one
// R15: Enabled set flag requests protocol interrupt
// R16: Own address matches set bits, write-one clears
// R17: SDA change delayed by hold field clocks
// R18: SCL rise delayed by setup field clocks
// R19: Stretch SCL after events until trigger write
// R20: Time-out counter runs when count nonzero, all flags clear and bus busy
// R21: Wake-up flag set on wake, write-one clears
// R22: Hardware set beats same-cycle software clear
// R23: Status zero after reset, reserved read zero
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module ipst_status_timing
  import ipst_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire ipst_req_type req,
  output logic [31:0] rdata,
  input wire ipst_evt_type evt,
  input wire logic master_mode,
  input wire logic tx_enable,
  input wire logic tx_bit,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe_n,
  output logic sda_out,
  output logic sda_oe_n,
  output logic protocol_irq,
  output logic slave_unaddress
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic scl_meta, scl_sync, scl_prev;
  logic sda_meta, sda_sync, sda_prev;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
    end
    else if (ce)
    begin
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  logic start_det, stop_det, scl_rise, scl_fall;
  assign start_det = scl_sync && scl_prev && sda_prev && !sda_sync;
  assign stop_det = scl_sync && scl_prev && !sda_prev && sda_sync;
  assign scl_rise = scl_sync && !scl_prev;
  assign scl_fall = !scl_sync && scl_prev;

  // ----------------------------------------
  // Status and control registers
  // ----------------------------------------
  logic [FLAG_COUNT-1:0] flags, next_flags, flag_set, flag_en, next_flag_en;
  logic bus_busy, next_bus_busy;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic match0, next_match0, match1, next_match1;
  logic wakeup_flag, next_wakeup_flag, wake_ack_done, next_wake_ack_done;
  logic wake_dir, next_wake_dir, slave_sel, next_slave_sel;
  logic slave_read, next_slave_read;
  logic proto_en, next_proto_en, stretch, next_stretch;
  logic [TIMEOUT_COUNT_W-1:0] timeout_count, next_timeout_count, to_cnt, next_to_cnt;
  logic [DELAY_W-1:0] hold_dly, next_hold_dly, setup_dly, next_setup_dly;
  logic next_slave_unaddress;
  logic [31:0] next_rdata, status_word;
  logic wr_ctl, wr_sts, wr_mat, to_hit, to_run, misplaced;

  always_comb
  begin
    status_word = READ_ZERO; // R23
    status_word[STS_WAKE_DIR] = wake_dir;
    status_word[STS_WAKE_ACK] = wake_ack_done;
    status_word[STS_SLAVE_READ] = slave_read;
    status_word[STS_SLAVE_SEL] = slave_sel;
    status_word[STS_FLAGS_HI:STS_FLAGS_LO] = flags[FLAG_ACK:FLAG_START];
    status_word[STS_BUS_BUSY] = bus_busy;
    status_word[STS_TIMEOUT] = flags[FLAG_TIMEOUT];
  end

  always_comb
  begin
    wr_ctl = req.wr && (req.addr == OFS_PROTOCOL_CONTROL);
    wr_sts = req.wr && (req.addr == OFS_PROTOCOL_STATUS);
    wr_mat = req.wr && (req.addr == OFS_ADDRESS_MATCH_STATUS);
    // Misplaced: inside a byte, before its acknowledge clock
    misplaced = bus_busy && (bit_cnt != 4'h0) && (start_det || stop_det);
    // Hit only while counting, else a count of one fires on an idle bus
    to_run = (timeout_count != TIMEOUT_COUNT_RESET) && (flags == FLAGS_RESET) && bus_busy;
    to_hit = to_run && (to_cnt == timeout_count - 10'h001);

    flag_set = FLAGS_RESET;
    flag_set[FLAG_ACK] = evt.ack && master_mode; // R05
    flag_set[FLAG_ERROR] = misplaced; // R06
    flag_set[FLAG_ARB] = evt.arb_lost; // R08
    flag_set[FLAG_NACK] = evt.nack && master_mode; // R09
    flag_set[FLAG_STOP] = stop_det; // R10
    flag_set[FLAG_START] = start_det && (master_mode || bus_busy); // R11
    flag_set[FLAG_TIMEOUT] = to_hit; // R13

    // Write one clears, set wins over clear
    next_flags = flags;
    if (wr_sts)
    begin
      next_flags[FLAG_ACK:FLAG_START] = flags[FLAG_ACK:FLAG_START] & ~req.wdata[STS_FLAGS_HI:STS_FLAGS_LO]; // R14
      next_flags[FLAG_TIMEOUT] = flags[FLAG_TIMEOUT] & ~req.wdata[STS_TIMEOUT]; // R14
    end
    next_flags = next_flags | flag_set; // R22

    next_bus_busy = bus_busy;
    if (start_det)
      next_bus_busy = 1'b1; // R12
    if (stop_det)
      next_bus_busy = 1'b0; // R12

    next_bit_cnt = bit_cnt;
    if (start_det || stop_det)
      next_bit_cnt = 4'h0;
    else if (scl_rise && bus_busy)
      next_bit_cnt = (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;

    next_match0 = (match0 && !(wr_mat && req.wdata[0])) || evt.addr0_match; // R16
    next_match1 = (match1 && !(wr_mat && req.wdata[1])) || evt.addr1_match; // R16

    next_wakeup_flag = (wakeup_flag && !(req.wr && req.addr == OFS_WAKE_STATUS && req.wdata[0]))
      || evt.woken; // R21
    next_wake_ack_done = wake_ack_done;
    next_wake_dir = wake_dir;
    // Release of the ack-done bit is blocked while the wake flag stands
    if (wr_sts && req.wdata[STS_WAKE_ACK] && !wakeup_flag)
      next_wake_ack_done = 1'b0; // R02
    if (evt.wake_ack)
    begin
      next_wake_ack_done = 1'b1; // R02
      next_wake_dir = evt.wake_dir; // R01
    end

    next_slave_sel = evt.slave_sel; // R04
    next_slave_read = evt.slave_read; // R03

    next_proto_en = proto_en;
    next_timeout_count = timeout_count;
    next_slave_unaddress = 1'b0;
    if (wr_ctl)
    begin
      next_proto_en = req.wdata[CTL_ENABLE];
      next_timeout_count = req.wdata[CTL_TIMEOUT_COUNT_HI:CTL_TIMEOUT_COUNT_LO];
      next_slave_unaddress = req.wdata[CTL_STOP]; // R07
    end

    // Stretch until trigger; STOP and disable also end it
    next_stretch = stretch;
    if ((wr_ctl && req.wdata[CTL_TRIGGER]) || !proto_en || stop_det)
      next_stretch = 1'b0; // R19
    if (proto_en && |flag_set && !stop_det)
      next_stretch = 1'b1; // R19

    // Counts only while every flag is clear and the bus is in use
    next_to_cnt = TIMEOUT_COUNT_RESET;
    if (to_run && !to_hit)
      next_to_cnt = to_cnt + 10'h001; // R20

    next_flag_en = flag_en;
    if (req.wr && req.addr == OFS_INT_ENABLE)
      next_flag_en = req.wdata[FLAG_COUNT-1:0];

    next_hold_dly = hold_dly;
    next_setup_dly = setup_dly;
    if (req.wr && req.addr == OFS_LINE_TIMING_CONTROL)
    begin
      next_hold_dly = req.wdata[TM_HOLD_HI:TM_HOLD_LO];
      next_setup_dly = req.wdata[TM_SETUP_HI:TM_SETUP_LO];
    end

    // Unmapped offsets read as zero
    next_rdata = READ_ZERO;
    if (req.rd)
    begin
      unique case (req.addr)
        OFS_WAKE_STATUS: next_rdata[0] = wakeup_flag;
        OFS_PROTOCOL_CONTROL:
        begin
          next_rdata[CTL_ENABLE] = proto_en;
          next_rdata[CTL_TIMEOUT_COUNT_HI:CTL_TIMEOUT_COUNT_LO] = timeout_count;
          next_rdata[CTL_TRIGGER] = stretch;
        end
        OFS_INT_ENABLE: next_rdata[FLAG_COUNT-1:0] = flag_en;
        OFS_PROTOCOL_STATUS: next_rdata = status_word;
        OFS_ADDRESS_MATCH_STATUS: next_rdata[1:0] = {match1, match0};
        OFS_LINE_TIMING_CONTROL:
        begin
          next_rdata[TM_HOLD_HI:TM_HOLD_LO] = hold_dly;
          next_rdata[TM_SETUP_HI:TM_SETUP_LO] = setup_dly;
        end
        default: next_rdata = READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      flags <= FLAGS_RESET; // R23
      flag_en <= FLAGS_RESET;
      bus_busy <= 1'b0;
      bit_cnt <= 4'h0;
      match0 <= 1'b0;
      match1 <= 1'b0;
      wakeup_flag <= 1'b0;
      wake_ack_done <= 1'b0;
      wake_dir <= 1'b0;
      slave_sel <= 1'b0;
      slave_read <= 1'b0;
      proto_en <= 1'b0;
      stretch <= 1'b0;
      timeout_count <= TIMEOUT_COUNT_RESET;
      to_cnt <= TIMEOUT_COUNT_RESET;
      hold_dly <= DELAY_RESET;
      setup_dly <= DELAY_RESET;
      slave_unaddress <= 1'b0;
      rdata <= READ_ZERO;
    end
    else if (ce)
    begin
      flags <= next_flags;
      flag_en <= next_flag_en;
      bus_busy <= next_bus_busy;
      bit_cnt <= next_bit_cnt;
      match0 <= next_match0;
      match1 <= next_match1;
      wakeup_flag <= next_wakeup_flag;
      wake_ack_done <= next_wake_ack_done;
      wake_dir <= next_wake_dir;
      slave_sel <= next_slave_sel;
      slave_read <= next_slave_read;
      proto_en <= next_proto_en;
      stretch <= next_stretch;
      timeout_count <= next_timeout_count;
      to_cnt <= next_to_cnt;
      hold_dly <= next_hold_dly;
      setup_dly <= next_setup_dly;
      slave_unaddress <= next_slave_unaddress;
      rdata <= next_rdata;
    end
  end

  assign protocol_irq = |(flags & flag_en); // R15

  // ----------------------------------------
  // SDA hold and setup timing
  // ----------------------------------------
  ipst_line_type line_state, next_line_state;
  logic [DELAY_W-1:0] dly_cnt, next_dly_cnt;
  logic next_sda_oe_n;

  always_comb
  begin
    next_line_state = line_state;
    next_dly_cnt = dly_cnt;
    next_sda_oe_n = tx_enable ? sda_oe_n : 1'b1;
    unique case (line_state)
      LINE_IDLE:
        if (tx_enable && scl_fall)
        begin
          next_line_state = LINE_HOLD;
          next_dly_cnt = hold_dly; // R17
        end
      LINE_HOLD:
        if (dly_cnt == DELAY_RESET)
        begin
          // Open drain: enable low pulls SDA to zero
          next_sda_oe_n = tx_bit; // R17
          next_line_state = (setup_dly == DELAY_RESET) ? LINE_IDLE : LINE_SETUP; // R18
          next_dly_cnt = setup_dly - 6'h01; // R18
        end
        else
          next_dly_cnt = dly_cnt - 6'h01; // R17
      LINE_SETUP:
        if (dly_cnt == DELAY_RESET)
          next_line_state = LINE_IDLE;
        else
          next_dly_cnt = dly_cnt - 6'h01; // R18
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      line_state <= LINE_IDLE;
      dly_cnt <= DELAY_RESET;
      sda_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      line_state <= next_line_state;
      dly_cnt <= next_dly_cnt;
      sda_oe_n <= next_sda_oe_n;
    end
  end

  // Holding SCL low covers both the setup gap and the stretch
  assign scl_oe_n = !(line_state == LINE_SETUP || stretch); // R18 R19
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_stop_flag_set: assert property (ce && stop_det |=> flags[FLAG_STOP] && !bus_busy) // R10
    else $error("stop did not set flag or clear busy");
  a_start_busy: assert property (ce && start_det && !stop_det |=> bus_busy) // R12
    else $error("start did not mark bus busy");
  a_set_beats_clear: assert property (ce && stop_det && wr_sts && req.wdata[9] |=> flags[FLAG_STOP]) // R22
    else $error("same-cycle clear lost a stop event");
  a_zero_write_keeps: assert property (ce && wr_sts && !req.wdata[13] && flags[FLAG_ACK] |=> flags[FLAG_ACK]) // R14
    else $error("writing zero changed ack flag");
  a_one_write_clears: assert property (ce && wr_sts && req.wdata[13] && !flag_set[FLAG_ACK] |=> !flags[FLAG_ACK]) // R14
    else $error("writing one left ack flag set");
  a_bus_error: assert property (ce && misplaced |=> flags[FLAG_ERROR]) // R06
    else $error("misplaced condition not flagged");
  a_irq_follows: assert property ($rose(flags[FLAG_NACK]) && flag_en[FLAG_NACK] |-> protocol_irq) // R15
    else $error("enabled flag gave no interrupt");
  a_match_zero: assert property (ce && evt.addr0_match |=> match0 ##1 (match0 || $past(wr_mat))) // R16
    else $error("address 0 match not held");
  a_wake_ack_keep: assert property (ce && wake_ack_done && wakeup_flag |=> wake_ack_done) // R02
    else $error("ack done released under wake flag");
  a_timeout_set: assert property (ce && to_hit |=> flags[FLAG_TIMEOUT] && to_cnt == TIMEOUT_COUNT_RESET) // R13 R20
    else $error("timeout hit did not set flag");
  a_setup_low: assert property (line_state == LINE_SETUP |-> !scl_oe_n) // R18
    else $error("SCL released during setup");
  a_stretch_hold: assert property (ce && proto_en && stop_det == 1'b0 && |flag_set |=> stretch [*2] or
    (stretch ##1 !stretch)) // R19
    else $error("no stretch after event");
  a_hold_delay: assert property (ce && line_state == LINE_IDLE && tx_enable && scl_fall && hold_dly == 6'h03
    ##1 (ce && tx_enable) [*3] |-> $stable(sda_oe_n) [*2]) // R17
    else $error("SDA changed before hold time");
  a_unmapped_read: assert property (ce && req.rd && req.addr == 8'h00 |=> rdata == READ_ZERO) // R23
    else $error("unmapped read not zero");

  c_start_seen: cover property (ce && start_det);
  c_stop_seen: cover property (ce && stop_det && flags[FLAG_START]);
  c_timeout_seen: cover property (ce && to_hit);
  c_stretch_release: cover property (stretch ##1 !stretch);

endmodule // ipst_status_timing

`default_nettype wire

// ==== src/ipst_pkg.sv ====
// Constants, register map and carrier types for the two-wire protocol
// status, address-match and line-timing block.
// Assumes a 32-bit register port with byte offsets and a 40 MHz clock.
package ipst_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_WAKE_STATUS = 8'h58;
  localparam logic [7:0] OFS_PROTOCOL_CONTROL = 8'h5C;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h60;
  localparam logic [7:0] OFS_PROTOCOL_STATUS = 8'h64;
  localparam logic [7:0] OFS_ADDRESS_MATCH_STATUS = 8'h88;
  localparam logic [7:0] OFS_LINE_TIMING_CONTROL = 8'h8C;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  // Event flags in interrupt-enable order; status bits follow below
  localparam int FLAG_COUNT = 7;
  localparam int FLAG_ACK = 6;
  localparam int FLAG_ERROR = 5;
  localparam int FLAG_ARB = 4;
  localparam int FLAG_NACK = 3;
  localparam int FLAG_STOP = 2;
  localparam int FLAG_START = 1;
  localparam int FLAG_TIMEOUT = 0;
  localparam int STS_WAKE_DIR = 17;
  localparam int STS_WAKE_ACK = 16;
  localparam int STS_SLAVE_READ = 15;
  localparam int STS_SLAVE_SEL = 14;
  localparam int STS_FLAGS_HI = 13;
  localparam int STS_FLAGS_LO = 8;
  localparam int STS_BUS_BUSY = 6;
  localparam int STS_TIMEOUT = 5;
  localparam int CTL_ENABLE = 31;
  localparam int CTL_TIMEOUT_COUNT_HI = 25;
  localparam int CTL_TIMEOUT_COUNT_LO = 16;
  localparam int CTL_TRIGGER = 5;
  localparam int CTL_STOP = 2;
  localparam int TM_HOLD_HI = 11;
  localparam int TM_HOLD_LO = 6;
  localparam int TM_SETUP_HI = 5;
  localparam int TM_SETUP_LO = 0;

  // ----------------------------------------
  // Reset values and widths
  // ----------------------------------------
  localparam int TIMEOUT_COUNT_W = 10;
  localparam int DELAY_W = 6;
  localparam logic [FLAG_COUNT-1:0] FLAGS_RESET = 7'h00;
  localparam logic [TIMEOUT_COUNT_W-1:0] TIMEOUT_COUNT_RESET = 10'h000;
  localparam logic [DELAY_W-1:0] DELAY_RESET = 6'h00;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ipst_req_type;

  // One-cycle pulses and levels from the protocol engine
  typedef struct packed {
    logic ack;
    logic nack;
    logic arb_lost;
    logic addr0_match;
    logic addr1_match;
    logic slave_sel;
    logic slave_read;
    logic woken;
    logic wake_ack;
    logic wake_dir;
  } ipst_evt_type;

  typedef enum logic [1:0] {LINE_IDLE, LINE_HOLD, LINE_SETUP} ipst_line_type;

endpackage

// ==== verif/ipst_bus_model.sv ====
// Behavioural model of the other masters and slaves on the two-wire bus.
// Assumes open-drain pads with pull-ups; the block pulls a line low while its enable is low.
`timescale 1ns/1ps
`default_nettype none

module ipst_bus_model
(
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  output logic scl_line,
  output logic sda_line
);
  logic scl_drv = 1'b1;
  logic sda_drv = 1'b1;

  // ----------------------------------------
  // Wired-and lines
  // ----------------------------------------
  // Pull-ups leave both lines high when idle
  assign scl_line = scl_drv & scl_oe_n;
  assign sda_line = sda_drv & sda_oe_n;

  // ----------------------------------------
  // Bus conditions, 200 ns bit time
  // ----------------------------------------
  // Clock stands still between frames
  task automatic start;
    sda_drv = 1'b0;
    #150;
  endtask

  // SCL is high on entry, SDA low
  task automatic stop;
    sda_drv = 1'b0;
    #100;
    sda_drv = 1'b1;
    #150;
  endtask

  task automatic pulses(input int n);
    repeat (n)
    begin
      scl_drv = 1'b0;
      #100;
      scl_drv = 1'b1;
      #100;
    end
  endtask

  // The rise here completes the ninth bit
  task automatic rstart;
    scl_drv = 1'b0;
    #50;
    sda_drv = 1'b1;
    #50;
    scl_drv = 1'b1;
    #100;
    sda_drv = 1'b0;
    #150;
  endtask

  task automatic scl_set(input logic v);
    scl_drv = v;
  endtask
endmodule // ipst_bus_model

`default_nettype wire

// ==== verif/ipst_status_timing_tb.sv ====
// Self-checking bench for the protocol status and line-timing block.
// Assumes the register port of the package and the bus model beside it.
`timescale 1ns/1ps
`default_nettype none

module ipst_status_timing_tb;
  import ipst_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  ipst_req_type req = '0;
  ipst_evt_type evt = '0;
  logic master_mode = 1'b1;
  logic tx_enable = 1'b0;
  logic tx_bit = 1'b1;
  logic [31:0] rdata;
  logic scl_line, sda_line, scl_out, scl_oe_n, sda_out, sda_oe_n, protocol_irq, slave_unaddress;
  int n_fail = 0;
  int n_compared = 0;
  int n;
  int m;

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  ipst_status_timing dut (.clk(clk), .rst(rst), .ce(ce), .req(req), .rdata(rdata), .evt(evt),
    .master_mode(master_mode), .tx_enable(tx_enable), .tx_bit(tx_bit), .scl_in(scl_line),
    .sda_in(sda_line), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .protocol_irq(protocol_irq), .slave_unaddress(slave_unaddress));

  ipst_bus_model bus (.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .scl_line(scl_line), .sda_line(sda_line));

  // ----------------------------------------
  // Access and check tasks
  // ----------------------------------------
  task automatic wrap_up;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk, input string name);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    chk(name, exp, rdata & msk);
  endtask

  // Bits: ack nack arb a0 a1 sel read woken wake_ack wake_dir
  task automatic pulse(input logic [9:0] p);
    @(posedge clk);
    evt <= ipst_evt_type'(evt | p);
    @(posedge clk);
    evt <= ipst_evt_type'(evt & ~p);
    repeat (2) @(posedge clk);
  endtask

  initial
  begin
    #300000;
    n_fail++;
    wrap_up();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rchk(8'h64, 32'h0000_0000, 32'hFFFF_FFFF, "status reset");
    rchk(8'h88, 32'h0000_0000, 32'hFFFF_FFFF, "match reset");
    rchk(8'h8C, 32'h0000_0000, 32'hFFFF_FFFF, "timing reset");
    wr(8'h90, 32'hFFFF_FFFF);
    rchk(8'h90, 32'h0000_0000, 32'hFFFF_FFFF, "unmapped");
    wr(8'h8C, 32'hFFFF_FFFF);
    rchk(8'h8C, 32'h0000_0FFF, 32'hFFFF_FFFF, "timing fields");
    wr(8'h64, 32'hFFFF_FFFF);
    rchk(8'h64, 32'h0000_0000, 32'hFFFF_FFFF, "status no self set");
    pulse(10'h380);
    rchk(8'h64, 32'h0000_2C00, 32'hFFFF_FFFF, "ack arb nack");
    wr(8'h64, 32'h0000_0000);
    rchk(8'h64, 32'h0000_2C00, 32'hFFFF_FFFF, "write zero keeps");
    wr(8'h64, 32'h0000_0800);
    rchk(8'h64, 32'h0000_2400, 32'hFFFF_FFFF, "write one clears");
    wr(8'h64, 32'h0000_2400);
    wr(8'h60, 32'h0000_0040);
    pulse(10'h200);
    chk("irq enabled", 32'h1, {31'h0, protocol_irq});
    wr(8'h60, 32'h0000_0020);
    #1;
    chk("irq masked", 32'h0, {31'h0, protocol_irq});
    wr(8'h60, 32'h0000_0000);
    // Same-edge set and clear
    @(posedge clk);
    req <= '{addr: 8'h64, wdata: 32'h0000_2000, wr: 1'b1, rd: 1'b0};
    evt.ack <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
    evt.ack <= 1'b0;
    rchk(8'h64, 32'h0000_2000, 32'hFFFF_FFFF, "set beats clear");
    wr(8'h64, 32'h0000_2000);
    pulse(10'h060);
    rchk(8'h88, 32'h0000_0003, 32'hFFFF_FFFF, "both matched");
    wr(8'h88, 32'h0000_0001);
    rchk(8'h88, 32'h0000_0002, 32'hFFFF_FFFF, "match0 cleared");
    wr(8'h88, 32'h0000_0002);
    @(posedge clk);
    evt.slave_sel <= 1'b1;
    evt.slave_read <= 1'b1;
    rchk(8'h64, 32'h0000_C000, 32'hFFFF_FFFF, "slave levels");
    evt.slave_sel <= 1'b0;
    evt.slave_read <= 1'b0;
    rchk(8'h64, 32'h0000_0000, 32'hFFFF_FFFF, "slave released");
    pulse(10'h004);
    rchk(8'h58, 32'h0000_0001, 32'hFFFF_FFFF, "wake flag");
    pulse(10'h003);
    rchk(8'h64, 32'h0003_0000, 32'hFFFF_FFFF, "wake ack read dir");
    wr(8'h64, 32'h0001_0000);
    rchk(8'h64, 32'h0001_0000, 32'h0001_0000, "wake ack held");
    wr(8'h58, 32'h0000_0001);
    rchk(8'h58, 32'h0000_0000, 32'hFFFF_FFFF, "wake flag cleared");
    wr(8'h64, 32'h0001_0000);
    rchk(8'h64, 32'h0000_0000, 32'h0001_0000, "wake ack cleared");
    bus.start();
    rchk(8'h64, 32'h0000_0140, 32'h0000_3F60, "master start busy");
    bus.stop();
    rchk(8'h64, 32'h0000_0300, 32'h0000_3F60, "stop idle");
    wr(8'h64, 32'h0000_3F20);
    bus.start();
    bus.pulses(1);
    bus.stop();
    rchk(8'h64, 32'h0000_1000, 32'h0000_1000, "misplaced stop");
    wr(8'h5C, 32'h0000_0004);
    #1;
    chk("slave unaddress", 32'h1, {31'h0, slave_unaddress});
    wr(8'h64, 32'h0000_3F20);
    master_mode <= 1'b0;
    bus.start();
    rchk(8'h64, 32'h0000_0040, 32'h0000_1140, "slave first start");
    bus.pulses(8);
    bus.rstart();
    rchk(8'h64, 32'h0000_0140, 32'h0000_1140, "slave repeated start");
    bus.stop();
    master_mode <= 1'b1;
    wr(8'h5C, 32'h0005_0000);
    bus.start();
    wr(8'h64, 32'h0000_3F20);
    repeat (12) @(posedge clk);
    rchk(8'h64, 32'h0000_0060, 32'h0000_3F60, "timeout");
    bus.stop();
    wr(8'h5C, 32'h0000_0000);
    wr(8'h64, 32'h0000_3F20);
    // Hold 3, setup 2
    wr(8'h8C, 32'h0000_00C2);
    tx_bit <= 1'b0;
    tx_enable <= 1'b1;
    tick();
    bus.scl_set(1'b0);
    n = 0;
    while (sda_oe_n !== 1'b0 && n < 40)
    begin
      tick();
      n++;
    end
    chk("hold delay", 32'h1, {31'h0, (n >= 4 && n <= 8)});
    m = 0;
    while (scl_oe_n !== 1'b0 && m < 4)
    begin
      tick();
      m++;
    end
    m = 0;
    while (scl_oe_n === 1'b0 && m < 20)
    begin
      tick();
      m++;
    end
    chk("setup delay", 32'h2, m);
    tx_enable <= 1'b0;
    repeat (10) tick();
    bus.scl_set(1'b1);
    #200;
    wr(8'h64, 32'h0000_3F20);
    wr(8'h5C, 32'h8000_0000);
    pulse(10'h200);
    chk("stretch on flag", 32'h0, {31'h0, scl_oe_n});
    wr(8'h5C, 32'h8000_0020);
    repeat (2) @(posedge clk);
    #1;
    chk("trigger releases", 32'h1, {31'h0, scl_oe_n});
    chk("scl out level", 32'h0, {31'h0, scl_out});
    chk("sda out level", 32'h0, {31'h0, sda_out});
    wrap_up();
  end
endmodule // ipst_status_timing_tb

`default_nettype wire
